//--- ucttmr_top.sv
// How it works
// - Eighteen standard rates in two groups; aux_control bit 7 picks the group.
// - High-rate and test-rate locations take 00 or 01 and reset to 00.
// - Every rate generator tick stream runs at sixteen times its baud rate.
// - Divide-by-two feeds timers; rate generator and pin detectors stay undivided.
// - Each counter/timer is a 16-bit divider using the concatenated preset.
// - aux_control bits 6 to 4 pick counter source and counter or timer.
// - Two counters, one per block; outputs feed baud clocks and pins.
// - Output falling edge sets interrupt_status bit 3.
// - Reads of two locations start and stop; bus data is ignored.
// - Start loads the preset into the working count, except in time-out mode, where start is ignored.
// - Stop clears interrupt_status bit 3 in every mode; a set in the same cycle wins.
// - Timer mode gives a square wave with half period equal to preset.
// - Timer flags every falling edge and keeps running after stop.
// - Channels clocked by the counter/timer work in 16x mode.
// - Counter counts to zero, flags, drops output, then wraps silently.
// - Count value reads return the live count.
// - In time-out mode each received character reloads and restarts.
// - Command Ax arms time-out, clears ready, holds; Cx disarms.
module ucttmr_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic host_cs_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [5:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_rdata_oe,
  input wire logic [ucttmr_pkg::NUM_BLK-1:0] ct_ext_pin,
  input wire logic [ucttmr_pkg::NUM_CH-1:0] rx_char_load,
  output logic [ucttmr_pkg::NUM_CH-1:0] chan_clk16,
  output logic [ucttmr_pkg::NUM_CH-1:0] chan_16x_mode,
  output logic [ucttmr_pkg::NUM_BLK-1:0] ct_pin_out,
  output logic [ucttmr_pkg::NUM_BLK-1:0] counter_ready,
  output logic div2_active,
  output logic core_tick
);
  import ucttmr_pkg::*;

  logic [2:0] cs_sync_q;
  logic [2:0] rd_sync_q;
  logic [2:0] wr_sync_q;
  logic [5:0] addr_m_q;
  logic [5:0] addr_q;
  logic [7:0] wdata_m_q;
  logic [7:0] wdata_q;
  logic [NUM_BLK-1:0] pin_m_q;
  logic [NUM_BLK-1:0] pin_s_q;
  logic [NUM_BLK-1:0] pin_prev_q;
  logic rd_now;
  logic rd_was;
  logic wr_now;
  logic wr_was;
  logic rd_go;
  logic wr_go;
  logic in_bank;
  logic blk_sel;
  logic ch_sel;
  logic [1:0] ch_idx;

  logic [7:0] high_rate_q;
  logic [7:0] test_rate_q;
  logic div2_q;
  logic half_q;
  logic [7:0] aux_q [NUM_BLK];
  logic [7:0] mask_q [NUM_BLK];
  logic [7:0] preset_hi_q [NUM_BLK];
  logic [7:0] preset_lo_q [NUM_BLK];
  logic [NUM_BLK-1:0] ready_q;
  logic [7:0] csel_q [NUM_CH];
  logic [NUM_CH-1:0] to_on_q;
  logic [NUM_CH-1:0] brg_tick;
  logic [NUM_CH*4-1:0] rate_code;
  logic [NUM_CH-1:0] group_sel;
  logic [NUM_BLK-1:0] ct_out_prev_q;
  logic [7:0] rdata_d;
  logic base_tick;

  // Host strobes, address and data pass two flops; a third finds the edge.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cs_sync_q <= 3'h7;
      rd_sync_q <= 3'h7;
      wr_sync_q <= 3'h7;
      addr_m_q <= '0;
      addr_q <= '0;
      wdata_m_q <= '0;
      wdata_q <= '0;
    end else begin
      cs_sync_q <= {cs_sync_q[1:0], host_cs_n};
      rd_sync_q <= {rd_sync_q[1:0], host_rd_n};
      wr_sync_q <= {wr_sync_q[1:0], host_wr_n};
      addr_m_q <= host_addr;
      addr_q <= addr_m_q;
      wdata_m_q <= host_wdata;
      wdata_q <= wdata_m_q;
    end
  end

  assign rd_now = !cs_sync_q[1] && !rd_sync_q[1];
  assign rd_was = !cs_sync_q[2] && !rd_sync_q[2];
  assign wr_now = !cs_sync_q[1] && !wr_sync_q[1];
  assign wr_was = !cs_sync_q[2] && !wr_sync_q[2];
  assign rd_go = rd_now && !rd_was;
  assign wr_go = wr_now && !wr_was;
  assign in_bank = !addr_q[BANK_BIT];
  assign blk_sel = addr_q[BLK_BIT];
  assign ch_sel = addr_q[CH_BIT];
  assign ch_idx = {blk_sel, ch_sel};

  // Global rate and clock options.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      high_rate_q <= RATE_LOW;
      test_rate_q <= RATE_LOW;
      div2_q <= 1'b0;
    end else if (wr_go) begin
      if (addr_q == ADDR_HIGH_RATE) begin
        high_rate_q <= wdata_q;
      end
      if (addr_q == ADDR_TEST_RATE) begin
        test_rate_q <= wdata_q;
      end
      if (addr_q == ADDR_DIV2_SET) begin
        div2_q <= 1'b1;
      end
      if (addr_q == ADDR_DIV2_CLR) begin
        div2_q <= 1'b0;
      end
    end
  end

  // Halved clock as an enable for the counter/timer sources; rate generator and pin detectors stay undivided.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end
  assign base_tick = div2_q ? half_q : 1'b1;

  // External counter pins keep the undivided clock for edge detection.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
      pin_prev_q <= '0;
    end else begin
      pin_m_q <= ct_ext_pin;
      pin_s_q <= pin_m_q;
      pin_prev_q <= pin_s_q;
    end
  end

  genvar b;
  generate
    for (b = 0; b < NUM_BLK; b++) begin : g_blk
      ucttmr_ct_if cif ();
      logic [3:0] pre_q;
      logic pin_rise;
      logic pin16;
      logic xtal16;
      logic blk_hit;

      assign blk_hit = in_bank && (blk_sel == 1'(b));
      assign pin_rise = pin_s_q[b] && !pin_prev_q[b];
      assign pin16 = pin_rise && (pre_q == PRESCALE_LAST);
      assign xtal16 = base_tick && (pre_q == PRESCALE_LAST);

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          pre_q <= '0;
        end else if (aux_q[b][AUX_SRC_LSB +: 2] == SRC_PIN16) begin
          pre_q <= pin_rise ? pre_q + 1'b1 : pre_q;
        end else begin
          pre_q <= base_tick ? pre_q + 1'b1 : pre_q;
        end
      end

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          aux_q[b] <= AUX_RESET;
          mask_q[b] <= MASK_RESET;
          preset_hi_q[b] <= PRESET_RESET[15:8];
          preset_lo_q[b] <= PRESET_RESET[7:0];
        end else if (wr_go && blk_hit) begin
          case (addr_q[3:0])
            LOC_AUX: aux_q[b] <= wdata_q;
            LOC_ISR: mask_q[b] <= wdata_q;
            LOC_CNT_HIGH: preset_hi_q[b] <= wdata_q;
            LOC_CNT_LOW: preset_lo_q[b] <= wdata_q;
            default: ;
          endcase
        end
      end

      always_comb begin
        case (aux_q[b][AUX_SRC_LSB +: 2])
          SRC_PIN: cif.tick = pin_rise;
          SRC_PIN16: cif.tick = pin16;
          SRC_XTAL: cif.tick = base_tick;
          SRC_XTAL16: cif.tick = xtal16;
          default: cif.tick = 1'b0;
        endcase
      end
      assign cif.timer_mode = aux_q[b][AUX_TIMER_BIT];
      assign cif.timeout_mode = |to_on_q[2*b +: 2];
      assign cif.preset = {preset_hi_q[b], preset_lo_q[b]};
      assign cif.start = rd_go && blk_hit &&
                         (addr_q[3:0] == LOC_START);
      assign cif.stop = rd_go && blk_hit &&
                        (addr_q[3:0] == LOC_STOP);
      assign cif.to_arm = wr_go && blk_hit && (addr_q[2:0] == LOC_CMD) &&
                          (wdata_q[7:4] == CMD_TO_ON);
      assign cif.rx_load = |(rx_char_load[2*b +: 2] &
                             to_on_q[2*b +: 2]);

      ucttmr_counter u_ct (
        .clk(clk),
        .reset(reset),
        .c(cif.ctr)
      );

      // Set wins over clear for the ready flag.
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          ready_q[b] <= 1'b0;
        end else if (cif.ready_set) begin
          ready_q[b] <= 1'b1;
        end else if (cif.ready_clr) begin
          ready_q[b] <= 1'b0;
        end
      end

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          ct_out_prev_q[b] <= 1'b1;
          ct_pin_out[b] <= 1'b1;
          counter_ready[b] <= 1'b0;
        end else begin
          ct_out_prev_q[b] <= cif.ct_out;
          ct_pin_out[b] <= cif.ct_out;
          counter_ready[b] <= ready_q[b] && mask_q[b][ISR_READY_BIT];
        end
      end
    end
  endgenerate

  // Per-channel clock select and time-out enable.
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      logic ch_hit;
      logic ct_rise;
      assign ch_hit = wr_go && in_bank && (ch_idx == 2'(c));
      assign rate_code[c*4 +: 4] = csel_q[c][7:4];
      assign group_sel[c] = aux_q[c/2][AUX_GROUP_BIT];
      assign ct_rise = g_blk[c/2].cif.ct_out && !ct_out_prev_q[c/2];

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          csel_q[c] <= CSEL_RESET;
          to_on_q[c] <= 1'b0;
        end else if (ch_hit) begin
          if (addr_q[2:0] == LOC_CSEL) begin
            csel_q[c] <= wdata_q;
          end
          if (addr_q[2:0] == LOC_CMD && wdata_q[7:4] == CMD_TO_ON) begin
            to_on_q[c] <= 1'b1;
          end
          if (addr_q[2:0] == LOC_CMD && wdata_q[7:4] == CMD_TO_OFF) begin
            to_on_q[c] <= 1'b0;
          end
        end
      end

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          chan_clk16[c] <= 1'b0;
          chan_16x_mode[c] <= 1'b0;
        end else if (csel_q[c][7:4] == CSEL_CT) begin
          chan_clk16[c] <= ct_rise;
          chan_16x_mode[c] <= 1'b1;
        end else begin
          chan_clk16[c] <= brg_tick[c];
          chan_16x_mode[c] <= 1'b0;
        end
      end
    end
  endgenerate

  ucttmr_rate_gen #(
    .CHANNELS(NUM_CH)
  ) u_rate (
    .clk(clk),
    .reset(reset),
    .group_sel(group_sel),
    .high_rate(high_rate_q[0]),
    .test_rate(test_rate_q[0]),
    .rate_code(rate_code),
    .tick16(brg_tick)
  );

  // Read data; count values are the live working count.
  always_comb begin
    rdata_d = '0;
    if (in_bank) begin
      case (addr_q[3:0])
        LOC_ISR: rdata_d[ISR_READY_BIT] = ready_q[blk_sel];
        LOC_CNT_HIGH: rdata_d = blk_sel ? g_blk[1].cif.count[15:8] :
                                          g_blk[0].cif.count[15:8];
        LOC_CNT_LOW: rdata_d = blk_sel ? g_blk[1].cif.count[7:0] :
                                         g_blk[0].cif.count[7:0];
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      host_rdata <= '0;
      host_rdata_oe <= 1'b0;
    end else begin
      host_rdata <= rd_go ? rdata_d : host_rdata;
      host_rdata_oe <= rd_now;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div2_active <= 1'b0;
      core_tick <= 1'b0;
    end else begin
      div2_active <= div2_q;
      core_tick <= base_tick;
    end
  end
endmodule

//--- ucttmr_pkg.sv
package ucttmr_pkg;
  localparam int NUM_CH = 4;
  localparam int NUM_BLK = 2;
  // Register locations on the six-bit host address.
  localparam logic [5:0] ADDR_HIGH_RATE = 6'h2D;
  localparam logic [5:0] ADDR_TEST_RATE = 6'h39;
  localparam logic [5:0] ADDR_DIV2_SET = 6'h2E;
  localparam logic [5:0] ADDR_DIV2_CLR = 6'h2F;
  // Locations inside a block; bit 3 of the address picks the channel.
  localparam logic [3:0] LOC_AUX = 4'h4;
  localparam logic [3:0] LOC_ISR = 4'h5;
  localparam logic [3:0] LOC_CNT_HIGH = 4'h6;
  localparam logic [3:0] LOC_CNT_LOW = 4'h7;
  localparam logic [3:0] LOC_START = 4'hE;
  localparam logic [3:0] LOC_STOP = 4'hF;
  localparam logic [2:0] LOC_CSEL = 3'h1;
  localparam logic [2:0] LOC_CMD = 3'h2;
  localparam int BLK_BIT = 4;
  localparam int CH_BIT = 3;
  localparam int BANK_BIT = 5;
  // Field layouts and codes.
  localparam int AUX_GROUP_BIT = 7;
  localparam int AUX_TIMER_BIT = 6;
  localparam int AUX_SRC_LSB = 4;
  localparam int ISR_READY_BIT = 3;
  localparam logic [1:0] SRC_PIN = 2'h0;
  localparam logic [1:0] SRC_PIN16 = 2'h1;
  localparam logic [1:0] SRC_XTAL = 2'h2;
  localparam logic [1:0] SRC_XTAL16 = 2'h3;
  localparam logic [3:0] CSEL_CT = 4'hD;
  localparam logic [3:0] CMD_TO_ON = 4'hA;
  localparam logic [3:0] CMD_TO_OFF = 4'hC;
  localparam logic [7:0] RATE_LOW = 8'h00;
  localparam logic [7:0] RATE_HIGH = 8'h01;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] CSEL_RESET = 8'h00;
  localparam logic [15:0] PRESET_RESET = 16'h0000;
  localparam logic [3:0] PRESCALE_LAST = 4'hF;
  localparam int DIV_W = 13;
  localparam int RATE_RATIO = 16;
endpackage

//--- ucttmr_ct_if.sv
interface ucttmr_ct_if;
  import ucttmr_pkg::*;
  logic tick;
  logic timer_mode;
  logic timeout_mode;
  logic [15:0] preset;
  logic start;
  logic stop;
  logic to_arm;
  logic rx_load;
  logic [15:0] count;
  logic ct_out;
  logic ready_set;
  logic ready_clr;
  modport ctl (output tick, timer_mode, timeout_mode, preset, start, stop,
    to_arm, rx_load, input count, ct_out, ready_set, ready_clr);
  modport ctr (input tick, timer_mode, timeout_mode, preset, start, stop,
    to_arm, rx_load, output count, ct_out, ready_set, ready_clr);
endinterface

//--- ucttmr_rate_gen.sv
module ucttmr_rate_gen #(
  parameter int CHANNELS = ucttmr_pkg::NUM_CH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [CHANNELS-1:0] group_sel,
  input wire logic high_rate,
  input wire logic test_rate,
  input wire logic [CHANNELS*4-1:0] rate_code,
  output logic [CHANNELS-1:0] tick16
);
  import ucttmr_pkg::*;

  // Divisors of the crystal clock giving sixteen ticks per bit.
  function automatic logic [DIV_W-1:0] divisor(input logic grp,
                                               input logic [3:0] code);
    logic [DIV_W-1:0] d;
    d = '0;
    case ({grp, code})
      5'h00: d = 13'h1200;
      5'h01, 5'h11: d = 13'h082E;
      5'h02, 5'h12: d = 13'h06B1;
      5'h03: d = 13'h0480;
      5'h04, 5'h14: d = 13'h0300;
      5'h05, 5'h15: d = 13'h0180;
      5'h06, 5'h16: d = 13'h00C0;
      5'h07: d = 13'h00DB;
      5'h08, 5'h18: d = 13'h0060;
      5'h09, 5'h19: d = 13'h0030;
      5'h0A: d = 13'h0020;
      5'h0B, 5'h1B: d = 13'h0018;
      5'h0C: d = 13'h0006;
      5'h10: d = 13'h0C00;
      5'h13: d = 13'h0600;
      5'h17: d = 13'h0073;
      5'h1A: d = 13'h0080;
      5'h1C: d = 13'h000C;
      default: d = '0;
    endcase
    return d;
  endfunction

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      logic [DIV_W-1:0] cnt_q;
      logic [DIV_W-1:0] div;
      always_comb begin
        div = divisor(group_sel[g], rate_code[g*4 +: 4]);
        if (test_rate) begin
          div = div >> 2;
        end else if (high_rate) begin
          div = div >> 1;
        end
      end
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          cnt_q <= '0;
          tick16[g] <= 1'b0;
        end else if (div == '0) begin
          cnt_q <= '0;
          tick16[g] <= 1'b0;
        end else if (cnt_q >= div - 1'b1) begin
          cnt_q <= '0;
          tick16[g] <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
          tick16[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

//--- ucttmr_counter.sv
module ucttmr_counter (
  input wire logic clk,
  input wire logic reset,
  ucttmr_ct_if.ctr c
);
  import ucttmr_pkg::*;

  logic [15:0] count_q;
  logic out_q;
  logic run_q;
  logic set_q;
  logic as_timer;
  logic advance;
  logic terminal;

  assign as_timer = c.timer_mode && !c.timeout_mode;
  assign advance = c.tick && (run_q || as_timer);
  assign terminal = as_timer ? (count_q <= 16'h0001) : (count_q == 16'h0001);
  assign c.count = count_q;
  assign c.ct_out = out_q;
  assign c.ready_set = set_q;
  // Stop, arming time-out and a received character clear the ready flag.
  assign c.ready_clr = c.stop || c.to_arm ||
                       (c.timeout_mode && c.rx_load);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_q <= '0;
      out_q <= 1'b1;
      run_q <= 1'b0;
    end else if (c.to_arm) begin
      run_q <= 1'b0;
      out_q <= 1'b1;
    end else if (c.timeout_mode && c.rx_load) begin
      count_q <= c.preset;
      run_q <= 1'b1;
    end else if (!c.timeout_mode && c.start) begin
      count_q <= c.preset;
      run_q <= 1'b1;
      out_q <= 1'b1;
    end else if (!c.timeout_mode && c.stop && !as_timer) begin
      run_q <= 1'b0;
    end else if (advance) begin
      if (as_timer && terminal) begin
        count_q <= c.preset;
        out_q <= ~out_q;
      end else begin
        count_q <= count_q - 1'b1;
        if (terminal) begin
          out_q <= 1'b0;
          if (c.timeout_mode) begin
            run_q <= 1'b0;
          end
        end
      end
    end
  end

  // One pulse whenever the output falls or the time-out expires.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      set_q <= 1'b0;
    end else begin
      set_q <= advance && terminal && !c.to_arm &&
               (c.timeout_mode ? 1'b1 : out_q) &&
               !(c.timeout_mode && c.rx_load) &&
               !(!c.timeout_mode && c.start);
    end
  end
endmodule

//--- ucttmr_top_props.sv
module ucttmr_top_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic host_cs_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [7:0] host_rdata,
  input wire logic host_rdata_oe,
  input wire logic [ucttmr_pkg::NUM_CH-1:0] chan_16x_mode,
  input wire logic div2_active,
  input wire logic core_tick
);
  import ucttmr_pkg::*;
  logic rd_on;
  logic wr_on;
  assign rd_on = !host_cs_n && !host_rd_n;
  assign wr_on = !host_cs_n && !host_wr_n;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  core_full_a: assert property (
    !$past(reset) && !div2_active && !$past(div2_active) |-> core_tick)
    else $error("core tick missing while undivided");
  core_half_a: assert property (
    !$past(reset) && !$past(reset, 2) && div2_active && $past(div2_active)
    |-> core_tick != $past(core_tick))
    else $error("core tick does not alternate while divided");
  div2_write_a: assert property (
    $changed(div2_active) |-> $past(wr_on))
    else $error("divide select changed without a write");
  mode_write_a: assert property (
    $changed(chan_16x_mode) |-> $past(wr_on))
    else $error("sampling mode changed without a write");
  oe_rise_a: assert property (
    $rose(host_rdata_oe) |-> $past(rd_on) && $past(rd_on, 2))
    else $error("read enable rose without a read strobe");
  oe_hold_a: assert property (
    rd_on && $past(rd_on) && $past(rd_on, 2) && $past(rd_on, 3) &&
    $past(rd_on, 4) |-> host_rdata_oe)
    else $error("read enable missing during a long read");
  oe_drop_a: assert property (
    $fell(host_rdata_oe) |-> !$past(rd_on) && !$past(rd_on, 2))
    else $error("read enable fell while strobe held");
  data_move_a: assert property (
    $changed(host_rdata) |-> $rose(host_rdata_oe))
    else $error("read data changed outside a read");
  write_quiet_a: assert property (
    wr_on && $past(wr_on) && $past(wr_on, 2) |-> !host_rdata_oe)
    else $error("read enable high during a write");
endmodule

bind ucttmr_top ucttmr_top_props u_props (
  .clk(clk),
  .reset(reset),
  .host_cs_n(host_cs_n),
  .host_rd_n(host_rd_n),
  .host_wr_n(host_wr_n),
  .host_rdata(host_rdata),
  .host_rdata_oe(host_rdata_oe),
  .chan_16x_mode(chan_16x_mode),
  .div2_active(div2_active),
  .core_tick(core_tick)
);

//--- ucttmr_host_model.sv
module ucttmr_host_model (
  input wire logic clk,
  input wire logic [7:0] host_rdata,
  input wire logic host_rdata_oe,
  output logic host_cs_n,
  output logic host_rd_n,
  output logic host_wr_n,
  output logic [5:0] host_addr,
  output logic [7:0] host_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    host_cs_n = 1'b1;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    host_addr = 6'h00;
    host_wdata = 8'h00;
  end
  // Strobes stay low at least six cycles and idle four, for the synchronisers.
  task automatic access(input logic [5:0] a, input logic wr,
    input logic [7:0] d, output logic [7:0] q);
    int n;
    @(negedge clk);
    host_addr = a;
    host_wdata = wr ? d : ~host_wdata;
    @(negedge clk);
    host_cs_n = 1'b0;
    host_rd_n = wr;
    host_wr_n = !wr;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (n < 6 || (!wr && host_rdata_oe !== 1'b1 && n < 20));
    q = host_rdata;
    host_cs_n = 1'b1;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    repeat (4) @(negedge clk);
    host_addr = ~a;
    host_wdata = ~host_wdata;
  endtask
endmodule

//--- tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ucttmr_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic host_cs_n, host_rd_n, host_wr_n, host_rdata_oe;
  logic [5:0] host_addr;
  logic [7:0] host_wdata, host_rdata, q;
  logic [1:0] ct_ext_pin = 2'h0;
  logic [3:0] rx_char_load = 4'h0;
  logic [3:0] chan_clk16, chan_16x_mode;
  logic [1:0] ct_pin_out, counter_ready;
  logic div2_active, core_tick;
  int mismatches = 0;
  int cmp_count = 0;
  int n;
  always #10 clk = ~clk;
  ucttmr_top DUT (.clk(clk), .reset(reset), .host_cs_n(host_cs_n),
    .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rdata_oe(host_rdata_oe), .ct_ext_pin(ct_ext_pin),
    .rx_char_load(rx_char_load), .chan_clk16(chan_clk16),
    .chan_16x_mode(chan_16x_mode), .ct_pin_out(ct_pin_out),
    .counter_ready(counter_ready), .div2_active(div2_active),
    .core_tick(core_tick));
  ucttmr_host_model u_host (.clk(clk), .host_rdata(host_rdata),
    .host_rdata_oe(host_rdata_oe), .host_cs_n(host_cs_n),
    .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_addr(host_addr),
    .host_wdata(host_wdata));
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_n(string nm, int e, int g);
    cmp_count++;
    if (g != e) begin
      mismatches++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] d);
    logic [7:0] x;
    u_host.access(a, 1'b1, d, x);
  endtask
  task automatic rd(logic [5:0] a, output logic [7:0] d);
    u_host.access(a, 1'b0, 8'h00, d);
  endtask
  task automatic wait_ready(int b, logic v, int lim, output int k);
    k = 0;
    while (counter_ready[b] !== v && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask
  // Cycles between two rate ticks; zero when none shows up.
  task automatic tick_gap(int ch, output int k);
    int w;
    w = 0;
    k = 0;
    while (chan_clk16[ch] !== 1'b1 && w < 2000) begin
      @(negedge clk);
      w++;
    end
    if (w < 2000) begin
      do begin
        @(negedge clk);
        k++;
      end while (chan_clk16[ch] !== 1'b1 && k < 2000);
    end
  endtask
  // Cycles between two falling edges of a counter output.
  task automatic fall_gap(int b, output int k);
    int w;
    logic p;
    w = 0;
    k = 0;
    p = ct_pin_out[b];
    while (!(p === 1'b1 && ct_pin_out[b] === 1'b0) && w < 100) begin
      p = ct_pin_out[b];
      @(negedge clk);
      w++;
    end
    do begin
      p = ct_pin_out[b];
      @(negedge clk);
      k++;
    end while (!(p === 1'b1 && ct_pin_out[b] === 1'b0) && k < 100);
  endtask
  task automatic pulse_rx();
    @(negedge clk);
    rx_char_load = 4'h1;
    @(negedge clk);
    rx_char_load = 4'h0;
  endtask
  task automatic pin_pulse();
    repeat (3) @(negedge clk);
    ct_ext_pin[0] = 1'b1;
    repeat (3) @(negedge clk);
    ct_ext_pin[0] = 1'b0;
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #600000;
    mismatches++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    chk8("pin_out", 8'h03, {6'h00, ct_pin_out});
    chk8("ready", 8'h00, {6'h00, counter_ready});
    n = 0;
    repeat (20) @(negedge clk) n += int'(core_tick);
    chk_n("full ticks", 20, n);
    wr(ADDR_DIV2_SET, 8'h00);
    chk8("div2", 8'h01, {7'h00, div2_active});
    n = 0;
    repeat (20) @(negedge clk) n += int'(core_tick);
    chk_n("half ticks", 10, n);
    $display("clock test done");
    wr(6'h01, 8'hD0);
    chk8("ct mode", 8'h01, {7'h00, chan_16x_mode[0]});
    wr(6'h09, 8'hB0);
    chk8("brg mode", 8'h00, {7'h00, chan_16x_mode[1]});
    tick_gap(1, n);
    chk_n("9600 gap", 24, n);
    wr(ADDR_HIGH_RATE, RATE_HIGH);
    tick_gap(1, n);
    chk_n("high gap", 12, n);
    wr(ADDR_HIGH_RATE, RATE_LOW);
    wr(ADDR_TEST_RATE, 8'h01);
    tick_gap(1, n);
    chk_n("test gap", 6, n);
    wr(ADDR_TEST_RATE, 8'h00);
    tick_gap(1, n);
    chk_n("low gap", 24, n);
    wr(6'h04, 8'h80);
    wr(6'h09, 8'h30);
    tick_gap(1, n);
    chk_n("150 gap", 1536, n);
    wr(6'h09, 8'hE0);
    tick_gap(1, n);
    chk_n("no tick", 0, n);
    $display("rate test done");
    for (int b = 0; b < 2; b++) begin
      wr(6'(b * 16 + 4), 8'h20);
      wr(6'(b * 16 + 5), 8'h08);
      wr(6'(b * 16 + 6), 8'h00);
      wr(6'(b * 16 + 7), 8'h04);
      rd(6'(b * 16 + 14), q);
      wait_ready(b, 1'b1, 60, n);
      chk8("ready set", 8'h01, {7'h00, counter_ready[b]});
      chk8("pin low", 8'h00, {7'h00, ct_pin_out[b]});
      chk8("other ready", 8'h00, {7'h00, counter_ready[1-b]});
      rd(6'(b * 16 + 5), q);
      chk8("status", 8'h08, q & 8'h08);
      rd(6'(b * 16 + 15), q);
      repeat (2) @(negedge clk);
      chk8("ready clr", 8'h00, {7'h00, counter_ready[b]});
      rd(6'(b * 16 + 6), q);
      chk8("wrapped", 8'hFF, q);
      wr(6'(b * 16 + 6), 8'h12);
      wr(6'(b * 16 + 7), 8'h34);
      rd(6'(b * 16 + 14), q);
      rd(6'(b * 16 + 15), q);
      rd(6'(b * 16 + 6), q);
      chk8("loaded", 8'h12, q);
    end
    $display("counter test done");
    wr(6'h04, 8'h60);
    wr(6'h06, 8'h00);
    wr(6'h07, 8'h03);
    rd(6'h0E, q);
    fall_gap(0, n);
    chk_n("timer gap", 12, n);
    rd(6'h0F, q);
    fall_gap(0, n);
    chk_n("after stop", 12, n);
    tick_gap(0, n);
    chk_n("ct clock gap", 12, n);
    wait_ready(0, 1'b1, 20, n);
    chk8("timer ready", 8'h01, {7'h00, counter_ready[0]});
    $display("timer test done");
    wr(6'h04, 8'h20);
    wr(6'h07, 8'h08);
    wr(6'h02, 8'hA0);
    repeat (40) @(negedge clk);
    chk8("armed", 8'h00, {7'h00, counter_ready[0]});
    pulse_rx();
    wait_ready(0, 1'b1, 60, n);
    chk_n("expiry time", 1, int'(n >= 14 && n < 60));
    pulse_rx();
    wait_ready(0, 1'b0, 6, n);
    chk8("restart", 8'h00, {7'h00, counter_ready[0]});
    wr(6'h02, 8'hC0);
    wr(6'h04, 8'h00);
    wr(6'h07, 8'h03);
    rd(6'h0F, q);
    rd(6'h0E, q);
    repeat (2) pin_pulse();
    chk8("pin early", 8'h00, {7'h00, counter_ready[0]});
    pin_pulse();
    wait_ready(0, 1'b1, 20, n);
    chk8("pin ready", 8'h01, {7'h00, counter_ready[0]});
    rd(6'h05, q);
    chk8("pin status", 8'h08, q & 8'h08);
    rd(6'h3F, q);
    chk8("unmapped", 8'h00, q);
    $display("timeout test done");
    test_done();
  end
endmodule
